// File: src/mem_space_decoder.sv
// Data and program address decoder with internal RAM, banks, bit area and stack.
// Assumes the core presents one access per cycle and waits two cycles for read data, three for indirect reads.
`timescale 1ns/10ps
`include "mem_space_regs.svh"

// What this block does
// RULE1 - Program space is 64 kB; only the first 8, 4 or 2 kB is flash.
// RULE2 - Last flash byte is the lock byte governing read, write and erase.
// RULE3 - Program addresses beyond the lock byte are reserved and unmapped.
// RULE4 - Flash is read by code reads; written only by redirected external moves.
// RULE5 - External moves target on-chip external RAM unless redirected to flash.
// RULE6 - Internal RAM has 256 bytes at internal addresses 0x00 to 0xFF.
// RULE7 - Lower 128 bytes reachable by both direct and indirect modes.
// RULE8 - Direct access above 0x7F goes to the register space.
// RULE9 - Indirect access above 0x7F goes to upper RAM, separate from registers.
// RULE10 - 0x00 to 0x1F hold four banks of eight; status word bits pick one.
// RULE11 - Indirect pointer comes from register 0 or 1 of the active bank.
// RULE12 - Bytes 0x20 to 0x2F are also 128 bits, address 8*offset plus bit.
// RULE13 - Bit or byte access is decided only by the instruction operand type.
// RULE14 - Push writes at pointer plus one, then increments the pointer.
// RULE15 - Reset loads pointer with 0x07; stack may sit anywhere in RAM.
// RULE16 - Sixteen-bit external moves ignore upper address byte; 256 bytes repeat.
// RULE17 - Registers with low nibble 0x0 or 0x8 allow bit access; others not.
// RULE18 - Core must not touch unassigned register addresses.
// RULE19 - Without external RAM, top four internal RAM bytes hold the identifier.
// RULE20 - With 512 bytes RAM, top four external RAM bytes hold the identifier.
// RULE21 - Pop reads at the pointer, then decrements the pointer.
module mem_space_decoder
   import mem_space_pkg::*;
#(
   parameter flash_size_type FLASH_SIZE = FLASH_8K,
   parameter bit             HAS_ONCHIP_EXTERNAL_RAM   = 1'b1,
   parameter logic [31:0]    UID_VALUE  = `UID_DEFAULT  // Arbitrary identifier value
) (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic            req,
   input  access_kind_type      kind,
   input  wire logic            wr,
   input  wire logic [15:0]     addr,
   input  wire logic            use_working_register_1,
   input  wire logic            ext_move_pointer_mode,
   input  wire logic            flash_redirect,
   input  wire logic [7:0]      wdata,
   input  wire logic            wbit,
   output logic      [7:0]      rdata,
   output logic                 rbit,
   output logic                 rvalid,
   output logic      [7:0]      stack_pointer,
   output logic      [1:0]      active_bank,
   output logic                 sfr_sel,
   output logic      [7:0]      sfr_addr,
   output logic                 sfr_bit_ok,
   output logic                 flash_sel,
   output logic      [15:0]     flash_addr,
   output logic                 flash_wr,
   output logic                 flash_lock_sel,
   output logic                 code_reserved,
   output logic                 bad_access
);

   // ============================================================
   // Decode helpers
   function automatic logic is_bit_sfr(input logic [7:0] a);
      is_bit_sfr = (a[3:0] == `SFR_NIB_BIT0) || (a[3:0] == `SFR_NIB_BIT8);  // RULE17
   endfunction

   function automatic logic [15:0] flash_last(input flash_size_type s);
      unique case (s)
         FLASH_8K: flash_last = `FLASH_LAST_8K;
         FLASH_4K: flash_last = `FLASH_LAST_4K;
         FLASH_2K: flash_last = `FLASH_LAST_2K;
         default:  flash_last = `FLASH_LAST_2K;
      endcase
   endfunction

   // ============================================================
   // State
   logic [7:0] sp_q, sp_d;
   logic [7:0] psw_q, psw_d;
   logic [7:0] rdata_q, rdata_d;
   logic       rbit_q, rbit_d;
   logic       rvalid_q, rvalid_d;
   logic [2:0] bitpos_q, bitpos_d;
   logic       src_iram_q, src_iram_d;
   logic       src_onchip_external_ram_q, src_onchip_external_ram_d;
   logic       src_uid_q, src_uid_d;
   logic [1:0] uid_idx_q, uid_idx_d;
   logic       bitop_q, bitop_d;
   logic       ptr_fetch_q, ptr_fetch_d;
   logic       ptr_wr_q, ptr_wr_d;
   logic [7:0] ptr_wdata_q, ptr_wdata_d;
   logic       bitwb_q, bitwb_d;
   logic [7:0] bitaddr_q, bitaddr_d;
   logic       bitval_q, bitval_d;
   logic [7:0] bit_merged;

   // RAM ports
   logic       iram_we;
   logic [7:0] iram_addr;
   logic [7:0] iram_wdata;
   logic [7:0] iram_rdata;
   logic       onchip_external_ram_we;
   logic [7:0] onchip_external_ram_addr;
   logic [7:0] onchip_external_ram_rdata;

   logic [1:0] bank;
   logic [7:0] bit_byte;
   logic [15:0] last;

   assign bank     = {psw_q[`PSW_BANK_HI], psw_q[`PSW_BANK_LO]};  // RULE10
   assign last     = flash_last(FLASH_SIZE);
   assign bit_byte = `BIT_BYTE_BASE + {4'h0, addr[6:3]};          // RULE12

   // ============================================================
   // Internal RAM, 256 bytes
   byte_ram #(.DEPTH(256), .AW(8)) u_iram (  // RULE6
      .clk   (clk),
      .we    (iram_we),
      .addr  (iram_addr),
      .wdata (iram_wdata),
      .rdata (iram_rdata)
   );

   // On-chip external RAM; unused when the variant has none
   byte_ram #(.DEPTH(256), .AW(8)) u_onchip_external_ram (
      .clk   (clk),
      .we    (onchip_external_ram_we),
      .addr  (onchip_external_ram_addr),
      .wdata (wdata),
      .rdata (onchip_external_ram_rdata)
   );

   // ============================================================
   // Access decode: next state and RAM controls
   always_comb begin
      sp_d        = sp_q;
      psw_d       = psw_q;
      bitpos_d    = bitpos_q;
      src_iram_d  = 1'b0;
      src_onchip_external_ram_d  = 1'b0;
      src_uid_d   = 1'b0;
      uid_idx_d   = uid_idx_q;
      bitop_d     = 1'b0;
      ptr_fetch_d = 1'b0;
      ptr_wr_d    = ptr_wr_q;
      ptr_wdata_d = ptr_wdata_q;
      iram_we     = 1'b0;
      iram_addr   = addr[7:0];
      iram_wdata  = wdata;
      onchip_external_ram_we     = 1'b0;
      onchip_external_ram_addr   = addr[7:0];                  // RULE16
      sfr_sel     = 1'b0;
      sfr_addr    = addr[7:0];
      sfr_bit_ok  = 1'b0;
      flash_sel   = 1'b0;
      flash_addr  = addr;                       // RULE1
      flash_wr    = 1'b0;
      flash_lock_sel = 1'b0;
      code_reserved  = 1'b0;
      bad_access     = 1'b0;
      if (ptr_fetch_q) begin
         // Second step of indirect access: pointer byte now read
         iram_addr  = iram_rdata;               // RULE9
         iram_we    = ptr_wr_q;
         iram_wdata = ptr_wdata_q;
         src_iram_d = !ptr_wr_q;
         if (!HAS_ONCHIP_EXTERNAL_RAM && iram_rdata >= `UID_BASE) begin
            iram_we   = 1'b0;                   // RULE19
            src_uid_d = !ptr_wr_q;
            uid_idx_d = iram_rdata[1:0];
         end
      end else if (bitwb_q) begin
         // Second step of a bit write: merged byte goes back
         iram_addr  = bitaddr_q;                // RULE12
         iram_we    = 1'b1;
         iram_wdata = bit_merged;
      end else if (req) begin
         unique case (kind)
            ACC_DIRECT: begin
               if (addr[7:0] > `LOWER_RAM_TOP) begin
                  sfr_sel = 1'b1;               // RULE8
                  sfr_bit_ok = is_bit_sfr(addr[7:0]);  // RULE17
                  if (wr && addr[7:0] == `SFR_ADDR_SP) begin
                     sp_d = wdata;
                  end
                  if (wr && addr[7:0] == `SFR_ADDR_PSW) begin
                     psw_d = wdata;
                  end
               end else begin
                  iram_we    = wr;              // RULE7
                  src_iram_d = !wr;
               end
            end
            ACC_INDIRECT: begin
               // Fetch pointer from working register 0 or 1 of active bank
               iram_addr   = {3'b000, bank, 2'b00, use_working_register_1};  // RULE11
               ptr_fetch_d = 1'b1;
               ptr_wr_d    = wr;
               ptr_wdata_d = wdata;
            end
            ACC_BIT: begin
               bitop_d = 1'b1;                  // RULE13
               if (addr[7]) begin
                  sfr_sel    = is_bit_sfr({addr[7:3], 3'b000});
                  sfr_addr   = {addr[7:3], 3'b000};
                  sfr_bit_ok = is_bit_sfr({addr[7:3], 3'b000});  // RULE17
                  bad_access = !sfr_bit_ok;
               end else begin
                  iram_addr  = bit_byte;        // RULE12
                  bitpos_d   = addr[2:0];
                  src_iram_d = !wr;
               end
            end
            ACC_CODE_READ: begin
               if (addr > last) begin
                  code_reserved = 1'b1;         // RULE3
               end else begin
                  flash_sel      = 1'b1;        // RULE4
                  flash_lock_sel = (addr == last);  // RULE2
               end
            end
            ACC_EXT_MOVE: begin
               if (flash_redirect && wr) begin
                  flash_sel  = (addr <= last);  // RULE4
                  flash_wr   = (addr <= last);
                  code_reserved  = (addr > last);
                  flash_lock_sel = (addr == last);
               end else if (HAS_ONCHIP_EXTERNAL_RAM) begin
                  onchip_external_ram_addr = ext_move_pointer_mode ? addr[7:0] : addr[7:0];  // RULE5
                  if (addr[7:0] >= `UID_BASE) begin
                     src_uid_d = !wr;           // RULE20
                     uid_idx_d = addr[1:0];
                  end else begin
                     onchip_external_ram_we    = wr;
                     src_onchip_external_ram_d = !wr;
                  end
               end else begin
                  bad_access = 1'b1;
               end
            end
            ACC_PUSH: begin
               iram_addr = sp_q + 8'h01;        // RULE14
               iram_we   = 1'b1;
               sp_d      = sp_q + 8'h01;
            end
            ACC_POP: begin
               iram_addr  = sp_q;               // RULE21
               src_iram_d = 1'b1;
               sp_d       = sp_q - 8'h01;
            end
            default: bad_access = 1'b1;
         endcase
      end
   end

   // Bit write is a read-modify-write done in the next cycle
   always_comb begin
      bit_merged = iram_rdata;
      bit_merged[bitpos_q] = bitval_q;  // RULE12
   end

   // Read data selection
   always_comb begin
      rdata_d  = rdata_q;
      rbit_d   = rbit_q;
      rvalid_d = src_iram_q || src_onchip_external_ram_q || src_uid_q;  // Valid together with the word it qualifies
      if (src_iram_q) begin
         rdata_d = iram_rdata;
         rbit_d  = bitop_q ? iram_rdata[bitpos_q] : rbit_q;  // RULE13
      end else if (src_onchip_external_ram_q) begin
         rdata_d = onchip_external_ram_rdata;
      end else if (src_uid_q) begin
         rdata_d = UID_VALUE[{uid_idx_q, 3'b000} +: 8];  // RULE19
      end
   end

   // ============================================================
   // Register state
   always_ff @(posedge clk) begin
      if (rst) begin
         sp_q        <= `SP_RESET;              // RULE15
         psw_q       <= 8'h00;
         rdata_q     <= 8'h00;
         rbit_q      <= 1'b0;
         rvalid_q    <= 1'b0;
         bitpos_q    <= 3'b000;
         src_iram_q  <= 1'b0;
         src_onchip_external_ram_q  <= 1'b0;
         src_uid_q   <= 1'b0;
         uid_idx_q   <= 2'b00;
         bitop_q     <= 1'b0;
         ptr_fetch_q <= 1'b0;
         ptr_wr_q    <= 1'b0;
         ptr_wdata_q <= 8'h00;
      end else begin
         sp_q        <= sp_d;
         psw_q       <= psw_d;
         rdata_q     <= rdata_d;
         rbit_q      <= rbit_d;
         rvalid_q    <= rvalid_d;
         bitpos_q    <= bitpos_d;
         src_iram_q  <= src_iram_d;
         src_onchip_external_ram_q  <= src_onchip_external_ram_d;
         src_uid_q   <= src_uid_d;
         uid_idx_q   <= uid_idx_d;
         bitop_q     <= bitop_d;
         ptr_fetch_q <= ptr_fetch_d;
         ptr_wr_q    <= ptr_wr_d;
         ptr_wdata_q <= ptr_wdata_d;
      end
   end

   // Bit write-back: target byte, bit value and a one-cycle strobe
   always_comb begin
      bitwb_d   = req && !ptr_fetch_q && !bitwb_q && kind == ACC_BIT && wr && !addr[7];
      bitaddr_d = bit_byte;
      bitval_d  = wbit;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         bitwb_q   <= 1'b0;
         bitaddr_q <= 8'h00;
         bitval_q  <= 1'b0;
      end else begin
         bitwb_q   <= bitwb_d;
         bitaddr_q <= bitaddr_d;
         bitval_q  <= bitval_d;
      end
   end

   assign rdata         = rdata_q;
   assign rbit          = rbit_q;
   assign rvalid        = rvalid_q;
   assign stack_pointer = sp_q;
   assign active_bank   = bank;

endmodule // mem_space_decoder

// File: shared/mem_space_regs.svh
// Address map constants for the memory space decoder.
// Assumes inclusion by the package and the design files only.
`ifndef MEM_SPACE_REGS_SVH
`define MEM_SPACE_REGS_SVH

// Flash sizes by variant, as byte counts minus one (last address)
`define FLASH_LAST_8K      16'h1FFF
`define FLASH_LAST_4K      16'h0FFF
`define FLASH_LAST_2K      16'h07FF
// Internal data space split
`define LOWER_RAM_TOP      8'h7F
`define BANK_REGION_TOP    8'h1F
`define BIT_BYTE_BASE      8'h20
`define BIT_ADDR_TOP       8'h7F
// Stack pointer value after reset
`define SP_RESET           8'h07
// Bank select field position in the status word
`define PSW_BANK_HI        4
`define PSW_BANK_LO        3
// Direct address of the stack pointer and status word
`define SFR_ADDR_SP        8'h81
`define SFR_ADDR_PSW       8'hD0
// Bit-addressable register low nibbles
`define SFR_NIB_BIT0       4'h0
`define SFR_NIB_BIT8       4'h8
// Unique identifier occupies the top four bytes
`define UID_BASE           8'hFC
`define UID_DEFAULT        32'h1234_5678

`endif

// File: shared/mem_space_pkg.sv
// Types shared by the memory space decoder files.
// Assumes the constants header is on the include path.
package mem_space_pkg;

   // Kind of access that the core presents
   typedef enum logic [2:0] {
      ACC_DIRECT,
      ACC_INDIRECT,
      ACC_BIT,
      ACC_CODE_READ,
      ACC_EXT_MOVE,
      ACC_PUSH,
      ACC_POP
   } access_kind_type;

   // Flash size variant
   typedef enum logic [1:0] {
      FLASH_8K,
      FLASH_4K,
      FLASH_2K
   } flash_size_type;

endpackage

// File: src/byte_ram.sv
// Single-port byte RAM with synchronous read, used for the data spaces.
// Assumes one access per cycle from the decoder on the same clock.
`timescale 1ns/10ps

module byte_ram #(
   parameter int DEPTH = 256,
   parameter int AW    = 8
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata
);

   logic [7:0] mem [DEPTH];
   logic [7:0] rdata_d;

   // ============================================================
   // Read path
   always_comb begin
      rdata_d = mem[addr];
   end

   // Write, and register the read word
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= rdata_d;
   end

endmodule // byte_ram

// File: bench/core_model.sv
// CPU core model: issues one access per call and waits for its answer.
// Assumes the decoder samples requests on the rising edge of clk.
`timescale 1ns/10ps

module core_model
   import mem_space_pkg::*;
(
   input  wire logic       clk,
   output logic            req,
   output access_kind_type kind,
   output logic            wr,
   output logic [15:0]     addr,
   output logic            use_working_register_1,
   output logic            ext_move_pointer_mode,
   output logic            flash_redirect,
   output logic [7:0]      wdata,
   output logic            wbit,
   input  wire logic       rvalid,
   input  wire logic       rbit,
   input  wire logic [7:0] rdata,
   input  wire logic [6:0] strobes
);
   // Idle values; the pointer form is always the 16-bit one
   initial begin
      req = 1'b0;
      kind = ACC_DIRECT;
      wr = 1'b0;
      addr = 16'h0000;
      use_working_register_1 = 1'b0;
      ext_move_pointer_mode = 1'b1;
      flash_redirect = 1'b0;
      wdata = 8'h00;
      wbit = 1'b0;
   end

   // One request held for one cycle, then up to four cycles for the answer
   task automatic access(input access_kind_type k, input logic w, input logic [15:0] a,
                         input logic [7:0] d, input logic r1, input logic fr,
                         output logic [6:0] st, output logic [7:0] rd, output logic rb);
      rd = 8'hxx;
      rb = 1'bx;
      @(posedge clk);
      req <= 1'b1;
      kind <= k;
      wr <= w;
      addr <= a;
      wdata <= d;
      wbit <= d[0];
      use_working_register_1 <= r1;
      flash_redirect <= fr;
      #1;
      st = strobes;
      @(posedge clk);
      req <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
      for (int n = 0; n < 4; n++) begin
         #1;
         if (rvalid === 1'b1) begin
            rd = rdata;
            rb = rbit;
         end
         @(posedge clk);
      end
   endtask
endmodule // core_model

// File: bench/mem_space_checker.sv
// Port checker for the memory space decoder.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps

module mem_space_checker
   import mem_space_pkg::*;
#(
   parameter flash_size_type FLASH_SIZE = FLASH_8K
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        req,
   input access_kind_type  kind,
   input wire logic        wr,
   input wire logic [15:0] addr,
   input wire logic        flash_redirect,
   input wire logic [7:0]  stack_pointer,
   input wire logic [1:0]  active_bank,
   input wire logic        sfr_sel,
   input wire logic [7:0]  sfr_addr,
   input wire logic        sfr_bit_ok,
   input wire logic        flash_sel,
   input wire logic        flash_wr,
   input wire logic        flash_lock_sel,
   input wire logic        code_reserved,
   input wire logic        rvalid
);
   localparam logic [15:0] LAST = (FLASH_SIZE == FLASH_8K) ? 16'h1FFF :
                                  (FLASH_SIZE == FLASH_4K) ? 16'h0FFF : 16'h07FF;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // ==========================================
   // Stack steps
   sequence taken_s(access_kind_type k);
      req && kind == k && !$past(req && kind == ACC_INDIRECT)
         && !$past(req && kind == ACC_BIT && wr && !addr[7]);
   endsequence

   AST_PUSH: assert property (taken_s(ACC_PUSH) |=> stack_pointer == 8'($past(stack_pointer) + 1))
      else $error("push pointer step");
   AST_POP: assert property (taken_s(ACC_POP) |=> stack_pointer == 8'($past(stack_pointer) - 1))
      else $error("pop pointer step");
   AST_POP_ANSWER: assert property (taken_s(ACC_POP) |-> ##2 rvalid)
      else $error("pop answer timing");
   AST_RST: assert property (disable iff (1'b0) rst |=> stack_pointer == 8'h07 && active_bank == 2'h0)
      else $error("reset pointer");

   // ==========================================
   // Decode strobes
   AST_DIR_HI: assert property (req && kind == ACC_DIRECT && addr[7] |-> sfr_sel && sfr_addr == addr[7:0])
      else $error("direct high decode");
   AST_DIR_LO: assert property (req && kind == ACC_DIRECT && !addr[7] |-> !sfr_sel)
      else $error("direct low decode");
   AST_IND: assert property (req && kind == ACC_INDIRECT |-> !sfr_sel)
      else $error("indirect decode");
   AST_BITOK: assert property (sfr_sel |-> sfr_bit_ok == (sfr_addr[2:0] == 3'h0))
      else $error("bit access flag");
   AST_CODE: assert property (req && kind == ACC_CODE_READ |-> flash_sel == (addr <= LAST)
      && flash_lock_sel == (addr == LAST) && code_reserved == (addr > LAST))
      else $error("code decode");
   AST_XMOVE: assert property (req && kind == ACC_EXT_MOVE && wr |-> flash_wr == (flash_redirect && addr <= LAST))
      else $error("external write target");
endmodule // mem_space_checker

bind mem_space_decoder mem_space_checker #(.FLASH_SIZE(FLASH_SIZE)) mem_space_checker_inst (.*);

// File: bench/tb.sv
// Self-checking bench for the memory space decoder.
// Assumes the core model and the checker are compiled before it.
`timescale 1ns/10ps

module tb;
   import mem_space_pkg::*;

   logic            clk, rst, req, wr, wbit, rbit, rvalid, rb;
   access_kind_type kind;
   logic [15:0]     addr, flash_addr;
   logic            use_working_register_1, ext_move_pointer_mode, flash_redirect;
   logic [7:0]      wdata, rdata, stack_pointer, sfr_addr, rd;
   logic [1:0]      active_bank;
   logic            sfr_sel, sfr_bit_ok, flash_sel, flash_wr, flash_lock_sel, code_reserved, bad_access;
   logic [6:0]      strobes, st;
   int              n_fail, samples_checked;

   typedef struct packed {
      access_kind_type k;
      logic [15:0]     a;
      logic [5:0]      e;
   } row_type;
   // Kind, address, expected {sfr, bit ok, flash, flash write, lock, reserved}
   localparam row_type ROWS [8] = '{'{ACC_DIRECT, 16'h0090, 6'h30}, '{ACC_DIRECT, 16'h0091, 6'h20},
      '{ACC_DIRECT, 16'h0098, 6'h30}, '{ACC_DIRECT, 16'h0040, 6'h00}, '{ACC_CODE_READ, 16'h0000, 6'h08},
      '{ACC_CODE_READ, 16'h1FFF, 6'h0A}, '{ACC_CODE_READ, 16'h2000, 6'h01}, '{ACC_CODE_READ, 16'hFFFF, 6'h01}};

   assign strobes = {sfr_sel, sfr_bit_ok, flash_sel, flash_wr, flash_lock_sel, code_reserved, bad_access};

   mem_space_decoder mem_space_decoder_inst (.*);
   core_model        core_model_inst (.*);

   // Clock of 8 ns
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Verdict and end of run
   task automatic report_and_stop();
      if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // One comparison
   task automatic check(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   // One access through the core model
   task automatic go(input access_kind_type k, input logic w, input logic [15:0] a, input logic [7:0] d,
                     input logic r1 = 1'b0, input logic fr = 1'b0);
      core_model_inst.access(k, w, a, d, r1, fr, st, rd, rb);
   endtask

   // Main sequence
   initial begin
      rst = 1'b1;
      n_fail = 0;
      samples_checked = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1;
      check(stack_pointer === 8'h07 && active_bank === 2'h0 && rvalid === 1'b0, "reset state");
      foreach (ROWS[i]) begin
         go(ROWS[i].k, 1'b0, ROWS[i].a, 8'h00);
         check(st[6:1] === ROWS[i].e, "decode strobes");
      end
      // Lower RAM by both modes; upper RAM apart from the registers
      go(ACC_DIRECT, 1'b1, 16'h0030, 8'hA5);
      go(ACC_DIRECT, 1'b1, 16'h0000, 8'h30);
      go(ACC_INDIRECT, 1'b0, 16'h0000, 8'h00);
      check(rd === 8'hA5, "indirect low");
      go(ACC_DIRECT, 1'b1, 16'h0001, 8'h90);
      go(ACC_INDIRECT, 1'b1, 16'h0000, 8'h3C, 1'b1);
      go(ACC_DIRECT, 1'b1, 16'h0090, 8'h00);
      go(ACC_INDIRECT, 1'b0, 16'h0000, 8'h00, 1'b1);
      check(rd === 8'h3C && st[6] === 1'b0, "upper RAM");
      // Each bank's first register steers the pointer
      for (int b = 0; b < 4; b++) begin
         go(ACC_DIRECT, 1'b1, 16'h0040 + 16'(b), 8'hB0 + 8'(b));
         go(ACC_DIRECT, 1'b1, 16'(8 * b), 8'h40 + 8'(b));
         go(ACC_DIRECT, 1'b1, 16'h00D0, 8'(b << 3));
         go(ACC_INDIRECT, 1'b0, 16'h0000, 8'h00);
         check(active_bank === 2'(b) && rd === 8'hB0 + 8'(b), "bank select");
      end
      // Bit area and its byte view
      go(ACC_DIRECT, 1'b1, 16'h0022, 8'h08);
      go(ACC_DIRECT, 1'b1, 16'h002F, 8'h80);
      go(ACC_BIT, 1'b0, 16'h0013, 8'h00);
      check(rb === 1'b1, "bit 13");
      go(ACC_BIT, 1'b0, 16'h0012, 8'h00);
      check(rb === 1'b0, "bit 12");
      go(ACC_BIT, 1'b0, 16'h007F, 8'h00);
      check(rb === 1'b1, "bit 7F");
      go(ACC_DIRECT, 1'b0, 16'h0022, 8'h00);
      check(rd === 8'h08, "byte view");
      go(ACC_BIT, 1'b1, 16'h0012, 8'h01);
      go(ACC_BIT, 1'b1, 16'h0013, 8'h00);
      go(ACC_DIRECT, 1'b0, 16'h0022, 8'h00);
      check(rd === 8'h04, "bit write");
      // Stack: last in, first out
      go(ACC_PUSH, 1'b1, 16'h0000, 8'h5A);
      check(stack_pointer === 8'h08, "push pointer");
      go(ACC_PUSH, 1'b1, 16'h0000, 8'h6B);
      go(ACC_DIRECT, 1'b0, 16'h0008, 8'h00);
      check(rd === 8'h5A && stack_pointer === 8'h09, "first push");
      go(ACC_POP, 1'b0, 16'h0000, 8'h00);
      check(rd === 8'h6B && stack_pointer === 8'h08, "first pop");
      go(ACC_POP, 1'b0, 16'h0000, 8'h00);
      check(rd === 8'h5A && stack_pointer === 8'h07, "second pop");
      // External moves: high byte ignored, redirect sends writes to flash
      go(ACC_EXT_MOVE, 1'b1, 16'h1234, 8'hC7);
      check(st[3] === 1'b0 && st[0] === 1'b0, "RAM write");
      go(ACC_EXT_MOVE, 1'b1, 16'h0034, 8'h11, 1'b0, 1'b1);
      check(st[3] === 1'b1, "flash write");
      go(ACC_EXT_MOVE, 1'b0, 16'hAB34, 8'h00);
      check(rd === 8'hC7, "alias");
      // Reset in mid-run
      go(ACC_PUSH, 1'b1, 16'h0000, 8'h77);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1;
      check(stack_pointer === 8'h07 && active_bank === 2'h0, "second reset");
      report_and_stop();
   end

   // Watchdog: the sequence needs well under 2000 cycles
   initial begin
      repeat (2000) @(posedge clk);
      n_fail++;
      report_and_stop();
   end
endmodule // tb
